// >>> core/dtpa_top.sv
`timescale 1ns/1ps
`default_nettype none
module dtpa_top #(
  parameter int DEPTH   = dtpa_pkg::PART_DEPTH,
  parameter int DISP    = dtpa_pkg::DISPATCH_MAX,
  parameter int READY_W = 8
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset_n,
  input  wire logic [1:0]            i_fetch_req,
  input  wire logic [1:0]            i_fetch_stall,
  input  wire logic [1:0]            i_l2_fill,
  input  wire logic [31:0]           i_fetch_line [2],
  input  wire logic [1:0]            i_uop_push,
  input  wire logic [1:0]            i_rob_push,
  input  wire logic [1:0]            i_rob_done,
  input  wire dtpa_pkg::dtpa_memop_t i_memop [2],
  input  wire logic [1:0]            i_store_retire,
  input  wire logic [READY_W-1:0]    i_sched_ready,
  input  wire logic [1:0]            i_tlb_fill,
  input  wire logic [31:0]           i_tlb_vaddr [2],
  input  wire logic [1:0]            i_gpr_we,
  input  wire logic [2:0]            i_gpr_idx [2],
  input  wire logic [31:0]           i_gpr_wdata [2],
  input  wire logic [31:0]           i_ip_next [2],
  input  wire logic [1:0]            i_ip_load,
  input  wire logic [31:0]           i_range_reg_wdata,
  input  wire logic                  i_range_reg_we,
  input  wire logic [1:0]            i_perf_event,
  output dtpa_pkg::dtpa_grant_t      o_fetch_grant,
  output dtpa_pkg::dtpa_grant_t      o_retire_grant,
  output dtpa_pkg::dtpa_grant_t      o_commit_grant,
  output logic [1:0]                 o_uop_full,
  output logic [1:0]                 o_rob_full,
  output logic [1:0]                 o_lsq_full,
  output logic [1:0]                 o_order_violation,
  output logic [READY_W-1:0]         o_dispatch,
  output logic [31:0]                o_ip [2],
  output logic [1:0]                 o_tlb_owner_hit,
  output logic [31:0]                o_range_reg,
  output logic [31:0]                o_perf_count
);
  localparam int HALF = DEPTH / 2;
  localparam int CW   = $clog2(DEPTH + 1);
  // Half-partition check shared by the uop queue, reorder buffer and load/store buffers
  function automatic logic at_half(input logic [CW-1:0] cnt);
    return cnt >= CW'(HALF);
  endfunction
  function automatic logic [CW-1:0] step(input logic [CW-1:0] c,
                                         input logic inc, input logic dec);
    return c + CW'(inc) - CW'(dec);
  endfunction
  // Stall holds until the thread's own fill returns
  logic [1:0] stalled_ff;
  always_ff @(posedge i_ref_clk) begin
    for (int t = 0; t < 2; t++) begin
      if (!i_reset_n) begin
        stalled_ff[t] <= 1'b0;
      end else if (i_fetch_stall[t]) begin
        stalled_ff[t] <= 1'b1;
      end else if (i_l2_fill[t]) begin
        stalled_ff[t] <= 1'b0;
      end
    end
  end
  // Per-thread two-entry streaming buffer; a full one stops fetch
  logic [1:0] isb_cnt_ff [2];
  logic [1:0] fetch_ok;
  logic [1:0] isb_pop;
  dtpa_pkg::dtpa_req_t freq [2];
  logic [1:0] ftake;
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      fetch_ok[t]   = i_fetch_req[t] && !stalled_ff[t] && !i_fetch_stall[t]
                      && isb_cnt_ff[t] != 2'(dtpa_pkg::ISB_DEPTH);
      freq[t].valid = fetch_ok[t];
      freq[t].data  = i_fetch_line[t];
      isb_pop[t]    = (isb_cnt_ff[t] != 2'h0) && i_uop_push[t]
                      && !o_uop_full[t];
    end
  end
  dtpa_alt_sel u_fetch_sel (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_req0    (freq[0]),
    .i_req1    (freq[1]),
    .o_take0   (ftake[0]),
    .o_take1   (ftake[1]),
    .o_grant   (o_fetch_grant)
  );
  always_ff @(posedge i_ref_clk) begin
    for (int t = 0; t < 2; t++) begin
      if (!i_reset_n) begin
        isb_cnt_ff[t] <= 2'h0;
      end else begin
        isb_cnt_ff[t] <= isb_cnt_ff[t] + 2'(ftake[t]) - 2'(isb_pop[t]);
      end
    end
  end
  // Partitioned uop queue, reorder buffer and load/store buffers
  logic [CW-1:0] uop_cnt_ff [2];
  logic [CW-1:0] rob_cnt_ff [2];
  logic [CW-1:0] lsq_cnt_ff [2];
  logic [1:0]    rob_inc, rob_ready, rtake, lsq_inc, lsq_dec, uop_dec, ctake;
  logic [7:0]    st_pend_ff [2];
  dtpa_pkg::dtpa_req_t rreq [2], creq [2];
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      rob_inc[t]    = i_rob_push[t] && !o_rob_full[t];
      rob_ready[t]  = i_rob_done[t] && (rob_cnt_ff[t] != '0);
      rreq[t].valid = rob_ready[t];
      rreq[t].data  = 32'(rob_cnt_ff[t]);
      lsq_inc[t]    = i_memop[t].valid && !o_lsq_full[t];
      lsq_dec[t]    = rtake[t] && lsq_cnt_ff[t] != '0;
      uop_dec[t]    = rob_inc[t] && uop_cnt_ff[t] != '0;
      creq[t].valid = st_pend_ff[t] != 8'h00;
      creq[t].data  = 32'(st_pend_ff[t]);
    end
  end
  dtpa_alt_sel u_retire_sel (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_req0    (rreq[0]),
    .i_req1    (rreq[1]),
    .o_take0   (rtake[0]),
    .o_take1   (rtake[1]),
    .o_grant   (o_retire_grant)
  );
  dtpa_alt_sel u_commit_sel (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_req0    (creq[0]),
    .i_req1    (creq[1]),
    .o_take0   (ctake[0]),
    .o_take1   (ctake[1]),
    .o_grant   (o_commit_grant)
  );
  // Counters update from the head in order, one entry per grant, except the uop queue, which drains one entry per rob push
  always_ff @(posedge i_ref_clk) begin
    for (int t = 0; t < 2; t++) begin
      if (!i_reset_n) begin
        uop_cnt_ff[t] <= '0;
        rob_cnt_ff[t] <= '0;
        lsq_cnt_ff[t] <= '0;
        st_pend_ff[t] <= 8'h00;
        o_uop_full[t] <= 1'b0;
        o_rob_full[t] <= 1'b0;
        o_lsq_full[t] <= 1'b0;
      end else begin
        uop_cnt_ff[t] <= step(uop_cnt_ff[t], isb_pop[t], uop_dec[t]);
        rob_cnt_ff[t] <= step(rob_cnt_ff[t], rob_inc[t], rtake[t]);
        lsq_cnt_ff[t] <= step(lsq_cnt_ff[t], lsq_inc[t], lsq_dec[t]);
        o_uop_full[t] <= at_half(step(uop_cnt_ff[t], isb_pop[t],
                                      uop_dec[t]));
        o_rob_full[t] <= at_half(step(rob_cnt_ff[t], rob_inc[t], rtake[t]));
        o_lsq_full[t] <= at_half(step(lsq_cnt_ff[t], lsq_inc[t],
                                      lsq_dec[t]));
        st_pend_ff[t] <= st_pend_ff[t] + 8'(i_store_retire[t])
                         - 8'(ctake[t]);
      end
    end
  end
  // Per-thread ordering: load hitting the most recent same-thread store address
  logic [31:0] last_st_ff [2];
  logic [1:0]  st_seen_ff;
  always_ff @(posedge i_ref_clk) begin
    for (int t = 0; t < 2; t++) begin
      if (!i_reset_n) begin
        last_st_ff[t]        <= dtpa_pkg::RST_WORD;
        st_seen_ff[t]        <= 1'b0;
        o_order_violation[t] <= 1'b0;
      end else begin
        o_order_violation[t] <= lsq_inc[t] && !i_memop[t].is_store
                                && st_seen_ff[t]
                                && i_memop[t].addr == last_st_ff[t];
        if (lsq_inc[t] && i_memop[t].is_store) begin
          last_st_ff[t] <= i_memop[t].addr;
          st_seen_ff[t] <= 1'b1;
        end
      end
    end
  end
  // Thread-blind dispatch of up to DISP ready ops, lowest slot first
  logic [READY_W-1:0] disp_sel;
  always_comb begin
    int n;
    n        = 0;
    disp_sel = '0;
    for (int i = 0; i < READY_W; i++) begin
      if (i_sched_ready[i] && n < DISP) begin
        disp_sel[i] = 1'b1;
        n           = n + 1;
      end
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_dispatch <= '0;
    end else begin
      o_dispatch <= disp_sel;
    end
  end
  // Shared translation array; each entry tagged with its owner
  logic [31:0] tlb_va_ff  [dtpa_pkg::TLB_ENTRIES];
  logic        tlb_tid_ff [dtpa_pkg::TLB_ENTRIES];
  logic        tlb_v_ff   [dtpa_pkg::TLB_ENTRIES];
  logic [2:0]  tlb_wp_ff;
  logic        tlb_wt;
  assign tlb_wt = ~i_tlb_fill[0];
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      tlb_wp_ff <= 3'h0;
      for (int e = 0; e < dtpa_pkg::TLB_ENTRIES; e++) begin
        tlb_v_ff[e]   <= 1'b0;
        tlb_tid_ff[e] <= 1'b0;
        tlb_va_ff[e]  <= dtpa_pkg::RST_WORD;
      end
    end else if (|i_tlb_fill) begin
      // One fill a cycle keeps the array single-ported
      tlb_va_ff[tlb_wp_ff]  <= i_tlb_vaddr[tlb_wt];
      tlb_tid_ff[tlb_wp_ff] <= tlb_wt;
      tlb_v_ff[tlb_wp_ff]   <= 1'b1;
      tlb_wp_ff             <= tlb_wp_ff + 3'h1;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    for (int t = 0; t < 2; t++) begin
      if (!i_reset_n) begin
        o_tlb_owner_hit[t] <= 1'b0;
      end else begin
        o_tlb_owner_hit[t] <= 1'b0;
        for (int e = 0; e < dtpa_pkg::TLB_ENTRIES; e++) begin
          if (tlb_v_ff[e] && tlb_tid_ff[e] == 1'(t)
              && tlb_va_ff[e] == i_tlb_vaddr[t]) begin
            o_tlb_owner_hit[t] <= 1'b1;
          end
        end
      end
    end
  end
  // Replicated architectural state and instruction pointers
  logic [31:0] gpr_ff [2][dtpa_pkg::GPR_COUNT];
  always_ff @(posedge i_ref_clk) begin
    for (int t = 0; t < 2; t++) begin
      if (!i_reset_n) begin
        o_ip[t] <= dtpa_pkg::RST_WORD;
        for (int r = 0; r < dtpa_pkg::GPR_COUNT; r++) begin
          gpr_ff[t][r] <= dtpa_pkg::RST_WORD;
        end
      end else begin
        if (i_ip_load[t]) begin
          o_ip[t] <= i_ip_next[t];
        end
        if (i_gpr_we[t]) begin
          gpr_ff[t][i_gpr_idx[t]] <= i_gpr_wdata[t];
        end
      end
    end
  end
  // Single copies shared by both threads
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_range_reg  <= dtpa_pkg::RST_WORD;
      o_perf_count <= dtpa_pkg::RST_WORD;
    end else begin
      if (i_range_reg_we) begin
        o_range_reg <= i_range_reg_wdata;
      end
      o_perf_count <= o_perf_count + 32'(i_perf_event[0])
                      + 32'(i_perf_event[1]);
    end
  end
endmodule
`default_nettype wire

// >>> core/dtpa_pkg.sv
package dtpa_pkg;
  localparam int NUM_THREADS   = 2;
  localparam int GPR_COUNT     = 8;
  localparam int ISB_DEPTH     = 2;
  localparam int DISPATCH_MAX  = 6;
  localparam int PART_DEPTH    = 16;
  localparam int TLB_ENTRIES   = 8;
  localparam int DATA_W        = 32;
  localparam logic RST_FAVOUR  = 1'b0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // One request from a thread at a selection point
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } dtpa_req_t;

  typedef struct packed {
    logic        valid;
    logic        tid;
    logic [31:0] data;
  } dtpa_grant_t;

  // Per-thread memory op into load/store partition
  typedef struct packed {
    logic        valid;
    logic        is_store;
    logic [31:0] addr;
    logic [31:0] data;
  } dtpa_memop_t;
endpackage

// >>> core/dtpa_alt_sel.sv
`timescale 1ns/1ps
`default_nettype none
// Two-thread alternating selector with single-thread fallback
module dtpa_alt_sel (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_reset_n,
  input  wire dtpa_pkg::dtpa_req_t  i_req0,
  input  wire dtpa_pkg::dtpa_req_t  i_req1,
  output logic                      o_take0,
  output logic                      o_take1,
  output dtpa_pkg::dtpa_grant_t     o_grant
);
  logic favour_ff;
  logic pick1;

  always_comb begin
    // Alternate when both ask; otherwise the lone requester wins
    if (i_req0.valid && i_req1.valid) begin
      pick1 = favour_ff;
    end else begin
      pick1 = i_req1.valid;
    end
    o_take0 = i_req0.valid && !pick1;
    o_take1 = i_req1.valid && pick1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      favour_ff <= dtpa_pkg::RST_FAVOUR;
    end else if (o_take0 || o_take1) begin
      favour_ff <= ~pick1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      o_grant <= '0;
    end else begin
      o_grant.valid <= o_take0 || o_take1;
      o_grant.tid   <= pick1;
      o_grant.data  <= pick1 ? i_req1.data : i_req0.data;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/dtpa_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dtpa_top_chk #(
  parameter int DISP    = dtpa_pkg::DISPATCH_MAX,
  parameter int READY_W = 8
) (
  input wire logic                  i_ref_clk,
  input wire logic                  i_reset_n,
  input wire logic [1:0]            i_fetch_req,
  input wire logic [1:0]            i_fetch_stall,
  input wire logic [1:0]            i_rob_done,
  input wire logic [READY_W-1:0]    i_sched_ready,
  input wire logic [31:0]           i_range_reg_wdata,
  input wire logic                  i_range_reg_we,
  input wire logic [1:0]            i_perf_event,
  input wire dtpa_pkg::dtpa_grant_t o_fetch_grant,
  input wire dtpa_pkg::dtpa_grant_t o_retire_grant,
  input wire logic [READY_W-1:0]    o_dispatch,
  input wire logic [31:0]           o_range_reg,
  input wire logic [31:0]           o_perf_count
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  AST_FETCH_SRC: assert property (o_fetch_grant.valid |->
    (o_fetch_grant.tid ? $past(i_fetch_req[1]) : $past(i_fetch_req[0])))
    else $error("fetch grant without request");
  // Stall blocks the fetch taken on the same edge
  AST_FETCH_STALL: assert property (i_fetch_stall[0] |=>
    !(o_fetch_grant.valid && o_fetch_grant.tid == 1'b0))
    else $error("stalled thread fetched");
  AST_RETIRE_SRC: assert property (o_retire_grant.valid |->
    (o_retire_grant.tid ? $past(i_rob_done[1]) : $past(i_rob_done[0])))
    else $error("retire grant without ready op");
  AST_DISP_SUB: assert property (
    (o_dispatch & ~$past(i_sched_ready)) == '0)
    else $error("dispatched op not ready");
  AST_DISP_CAP: assert property ($countones(o_dispatch) <= DISP)
    else $error("dispatch above limit");
  AST_DISP_ALL: assert property ($past(i_reset_n) &&
    $countones($past(i_sched_ready)) <= DISP
    |-> o_dispatch == $past(i_sched_ready))
    else $error("ready op held back");
  AST_RANGE_WR: assert property ($past(i_range_reg_we) &&
    $past(i_reset_n) |-> o_range_reg == $past(i_range_reg_wdata))
    else $error("range reg write lost");
  AST_PERF_HOLD: assert property (i_perf_event == 2'h0 |=>
    $stable(o_perf_count))
    else $error("counter moved without event");
endmodule

bind dtpa_top dtpa_top_chk #(
  .DISP    (DISP),
  .READY_W (READY_W)
) u_chk (
  .i_ref_clk         (i_ref_clk),
  .i_reset_n         (i_reset_n),
  .i_fetch_req       (i_fetch_req),
  .i_fetch_stall     (i_fetch_stall),
  .i_rob_done        (i_rob_done),
  .i_sched_ready     (i_sched_ready),
  .i_range_reg_wdata (i_range_reg_wdata),
  .i_range_reg_we    (i_range_reg_we),
  .i_perf_event      (i_perf_event),
  .o_fetch_grant     (o_fetch_grant),
  .o_retire_grant    (o_retire_grant),
  .o_dispatch        (o_dispatch),
  .o_range_reg       (o_range_reg),
  .o_perf_count      (o_perf_count)
);
`default_nettype wire

// >>> testbench/test_dual_thread_pipeline_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module test_dual_thread_pipeline_arbiter;
  logic                  i_ref_clk = 1'b0;
  logic                  i_reset_n, i_range_reg_we;
  logic [1:0]            i_fetch_req, i_fetch_stall, i_l2_fill, i_uop_push;
  logic [1:0]            i_rob_push, i_rob_done, i_store_retire, i_tlb_fill;
  logic [1:0]            i_gpr_we, i_ip_load, i_perf_event;
  logic [7:0]            i_sched_ready, o_dispatch;
  logic [2:0]            i_gpr_idx [2];
  logic [31:0]           i_fetch_line [2], i_tlb_vaddr [2], i_gpr_wdata [2];
  logic [31:0]           i_ip_next [2], o_ip [2], i_range_reg_wdata;
  logic [31:0]           o_range_reg, o_perf_count;
  logic [1:0]            o_uop_full, o_rob_full, o_lsq_full;
  logic [1:0]            o_order_violation, o_tlb_owner_hit;
  dtpa_pkg::dtpa_memop_t i_memop [2];
  dtpa_pkg::dtpa_grant_t o_fetch_grant, o_retire_grant, o_commit_grant;
  int                    err_total = 0;
  int                    tests_run = 0;
  int                    n;
  // Ready mask in the upper byte, expected dispatch below
  logic [15:0]           rows [7] = '{16'hFF3F, 16'h8181, 16'hFE7E,
                                      16'h7F3F, 16'h3F3F, 16'h0000, 16'hF0F0};

  dtpa_top DUT (
    .i_ref_clk         (i_ref_clk),
    .i_reset_n         (i_reset_n),
    .i_fetch_req       (i_fetch_req),
    .i_fetch_stall     (i_fetch_stall),
    .i_l2_fill         (i_l2_fill),
    .i_fetch_line      (i_fetch_line),
    .i_uop_push        (i_uop_push),
    .i_rob_push        (i_rob_push),
    .i_rob_done        (i_rob_done),
    .i_memop           (i_memop),
    .i_store_retire    (i_store_retire),
    .i_sched_ready     (i_sched_ready),
    .i_tlb_fill        (i_tlb_fill),
    .i_tlb_vaddr       (i_tlb_vaddr),
    .i_gpr_we          (i_gpr_we),
    .i_gpr_idx         (i_gpr_idx),
    .i_gpr_wdata       (i_gpr_wdata),
    .i_ip_next         (i_ip_next),
    .i_ip_load         (i_ip_load),
    .i_range_reg_wdata (i_range_reg_wdata),
    .i_range_reg_we    (i_range_reg_we),
    .i_perf_event      (i_perf_event),
    .o_fetch_grant     (o_fetch_grant),
    .o_retire_grant    (o_retire_grant),
    .o_commit_grant    (o_commit_grant),
    .o_uop_full        (o_uop_full),
    .o_rob_full        (o_rob_full),
    .o_lsq_full        (o_lsq_full),
    .o_order_violation (o_order_violation),
    .o_dispatch        (o_dispatch),
    .o_ip              (o_ip),
    .o_tlb_owner_hit   (o_tlb_owner_hit),
    .o_range_reg       (o_range_reg),
    .o_perf_count      (o_perf_count)
  );

  always #50 i_ref_clk = ~i_ref_clk;

  task automatic step(int c = 1);
    repeat (c) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic gnt(string nm, dtpa_pkg::dtpa_grant_t g, logic t);
    chk(nm, {1'b1, t}, {g.valid, g.tid});
  endtask

  task automatic close_out();
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Fresh reset per scenario keeps favour and occupancy known
  task automatic rst();
    i_reset_n = 1'b0;
    {i_range_reg_we, i_fetch_req, i_fetch_stall, i_l2_fill, i_uop_push,
     i_rob_push, i_rob_done, i_store_retire, i_tlb_fill, i_gpr_we,
     i_ip_load, i_perf_event, i_sched_ready, i_range_reg_wdata} = '0;
    i_memop = '{default: '0};
    i_gpr_idx = '{default: '0};
    i_gpr_wdata = '{default: '0};
    i_fetch_line = '{32'hA0A0_0000, 32'h0B0B_0001};
    i_tlb_vaddr = '{default: 32'h0000_5000};
    i_ip_next = '{32'h1234_0000, 32'h0000_9999};
    step(16);
    i_reset_n = 1'b1;
  endtask

  initial begin
    #400000;
    err_total++;
    close_out();
  end

  initial begin
    rst();
    chk("rst_perf", 32'h0, o_perf_count);
    foreach (rows[k]) begin
      i_sched_ready = rows[k][15:8];
      step();
      chk("dispatch", rows[k][7:0], o_dispatch);
    end
    // Downstream drains on so the streaming buffers never refuse
    {i_uop_push, i_rob_push, i_rob_done, i_fetch_req} = 8'hFF;
    for (int k = 0; k < 4; k++) begin
      step();
      gnt("fetch", o_fetch_grant, k[0]);
      chk("fetch_data", i_fetch_line[k[0]], o_fetch_grant.data);
    end
    i_fetch_req = 2'h2;
    repeat (3) begin
      step();
      gnt("fetch_solo", o_fetch_grant, 1'b1);
    end
    i_fetch_req = 2'h3;
    i_fetch_stall = 2'h1;
    repeat (3) begin
      step();
      i_fetch_stall = 2'h0;
      gnt("stall", o_fetch_grant, 1'b1);
    end
    i_fetch_req = 2'h0;
    i_l2_fill = 2'h1;
    step();
    i_l2_fill = 2'h0;
    i_fetch_req = 2'h3;
    step();
    gnt("refill", o_fetch_grant, 1'b0);
    step();
    gnt("refill", o_fetch_grant, 1'b1);
    rst();
    i_rob_push = 2'h1;
    step(7);
    chk("rob_full", 2'h0, o_rob_full);
    // Thread 0 hits its half while thread 1 keeps filling
    i_rob_push = 2'h3;
    step(2);
    chk("rob_full", 2'h1, o_rob_full);
    step();
    i_rob_push = 2'h0;
    i_rob_done = 2'h3;
    step();
    gnt("retire", o_retire_grant, 1'b0);
    step();
    gnt("retire", o_retire_grant, 1'b1);
    i_rob_done = 2'h1;
    repeat (2) begin
      step();
      gnt("retire_solo", o_retire_grant, 1'b0);
    end
    rst();
    n = 0;
    for (int k = 0; k < 10; k++) begin
      i_store_retire = (k < 2) ? 2'h3 : 2'h0;
      step();
      if (o_commit_grant.valid === 1'b1) begin
        chk("commit_tid", n[0], o_commit_grant.tid);
        n++;
      end
    end
    chk("commit_n", 32'h4, n);
    i_memop[0] = '{1'b1, 1'b1, 32'h0000_0100, 32'h0000_00AA};
    step();
    i_memop[0] = '{1'b1, 1'b0, 32'h0000_0100, 32'h0000_0000};
    i_memop[1] = '{1'b1, 1'b0, 32'h0000_0100, 32'h0000_0000};
    step();
    i_memop[0] = '0;
    chk("violation", 2'h1, o_order_violation);
    step(6);
    chk("violation", 2'h0, o_order_violation);
    step();
    i_memop[1] = '0;
    step();
    chk("lsq_full", 2'h2, o_lsq_full);
    i_tlb_fill = 2'h1;
    step();
    i_tlb_fill = 2'h0;
    step();
    chk("tlb_owner", 2'h1, o_tlb_owner_hit);
    // No rob drain: uop queue fills, then the streaming buffer refuses
    i_fetch_req = 2'h1;
    i_uop_push = 2'h1;
    step(10);
    chk("uop_full", 2'h1, o_uop_full);
    gnt("isb_fill", o_fetch_grant, 1'b0);
    step();
    chk("isb_full", 32'h0, o_fetch_grant.valid);
    i_fetch_req = 2'h0;
    i_uop_push = 2'h0;
    i_ip_load = 2'h1;
    i_range_reg_we = 1'b1;
    i_range_reg_wdata = 32'hCAFE_0001;
    i_perf_event = 2'h1;
    step();
    i_ip_load = 2'h0;
    i_range_reg_we = 1'b0;
    i_perf_event = 2'h2;
    step();
    i_perf_event = 2'h0;
    chk("ip0", 32'h1234_0000, o_ip[0]);
    chk("ip1", 32'h0000_0000, o_ip[1]);
    chk("range_reg", 32'hCAFE_0001, o_range_reg);
    chk("perf", 32'h0000_0002, o_perf_count);
    close_out();
  end
endmodule
`default_nettype wire
